// [rtl/bfib_defs.svh]
`ifndef BFIB_DEFS_SVH
`define BFIB_DEFS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define BFIB_IW_W          24
`define BFIB_PC_W          24
`define BFIB_DW_W          16

// ------------------------------------------------------------
// opcode patterns
// ------------------------------------------------------------
`define BFIB_INSF_OPC      12'h0A2
`define BFIB_INSL_OPC      16'h0A40
`define BFIB_W2_HI_ZERO    8'h00
`define BFIB_SWAP_OPC      24'hFE2000
`define BFIB_BRA_OPC       8'h37
`define BFIB_BRC_OPC       8'h31
`define BFIB_BRW_OPC       20'h02060

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BFIB_LOW_LSB       0
`define BFIB_HIGH_LSB      4
`define BFIB_WSRC_LSB      8
`define BFIB_LIT_LSB       8
`define BFIB_MODE_LSB      4
`define BFIB_ACTIVE_BIT    10
`define BFIB_SWAPDONE_BIT  11

// ------------------------------------------------------------
// reset values and cycle counts
// ------------------------------------------------------------
`define BFIB_ACTIVE_RST    1'b0
`define BFIB_SWAPDONE_RST  1'b0
`define BFIB_PC_STEP       24'h000002
`define BFIB_CYC_INSERT    3'd2
`define BFIB_CYC_SWAP      3'd2
`define BFIB_CYC_BR_BASIC  3'd2
`define BFIB_CYC_BR_EXT    3'd4

`endif

// [rtl/bfib_pkg.sv]
package bfib_pkg;

   typedef enum logic [2:0] {
      BFIB_OP_NONE  = 3'b000,
      BFIB_OP_INSF  = 3'b001,
      BFIB_OP_INSL  = 3'b010,
      BFIB_OP_SWAP  = 3'b011,
      BFIB_OP_BRA   = 3'b100,
      BFIB_OP_BRW   = 3'b101,
      BFIB_OP_BRC   = 3'b110
   } bfib_op_e;

   typedef enum logic [0:0] {
      BFIB_ST_IDLE = 1'b0,
      BFIB_ST_EXEC = 1'b1
   } bfib_state_e;

endpackage

// [rtl/bfib_field_insert.sv]
`timescale 1ns/1ps
`include "bfib_defs.svh"

module bfib_field_insert
   import bfib_pkg::*;
(
   // field bounds
   input  wire logic [3:0]             lowPos,
   input  wire logic [3:0]             highPos,
   // data
   input  wire logic [`BFIB_DW_W-1:0]  srcData,
   input  wire logic [`BFIB_DW_W-1:0]  dstData,
   output logic      [`BFIB_DW_W-1:0]  mergedData
);

   logic [`BFIB_DW_W-1:0] fieldMask;
   logic [`BFIB_DW_W-1:0] shiftedSrc;

   // ------------------------------------------------------------
   // per-bit mask, lowest field bit at the start position
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `BFIB_DW_W; i = i + 1) begin : g_mask
         assign fieldMask[i] = (4'(i) >= lowPos) && (4'(i) <= highPos);
      end
   endgenerate

   // source taken from bit 0; bits past the width fall outside the mask
   assign shiftedSrc = srcData << lowPos;
   assign mergedData = (dstData & ~fieldMask) | (shiftedSrc & fieldMask);

endmodule

// [rtl/bfib_branch_target.sv]
`timescale 1ns/1ps
`include "bfib_defs.svh"

module bfib_branch_target
   import bfib_pkg::*;
(
   // operands
   input  wire logic [`BFIB_PC_W-1:0]  pcNow,
   input  wire logic [15:0]            wordOffset,
   // result
   output logic      [`BFIB_PC_W-1:0]  pcTarget
);

   logic [`BFIB_PC_W-1:0] byteOffset;

   // doubled offset, sign-extended 17-bit value
   assign byteOffset = {{(`BFIB_PC_W-17){wordOffset[15]}}, wordOffset, 1'b0};
   assign pcTarget   = pcNow + `BFIB_PC_STEP + byteOffset;

endmodule

// [rtl/bfib_exec.sv]
`timescale 1ns/1ps
`include "bfib_defs.svh"

// How it works
// - file insert: two words, even address.
// - register source field starts at bit zero.
// - only field bits overwritten, nothing shifted.
// - start 0..15, width 1..16 bits.
// - low and high positions from codes.
// - literal insert: literal, mode, register select.
// - literal field starts at literal bit zero.
// - literal destination via register and mode.
// - panel swap acts only when both enabled and the unlock key is ok.
// - swap toggles active panel flag, bit 10.
// - successful swap sets swap done, bit 11.
// - panel swap single word, two cycles.
// - branch target is PC+2 plus twice offset.
// - branch two cycles basic, four extended.
// - computed branch adds doubled register, sign-extended.
// - computed branch encoding, four cycles extended, nop.
// - carry branch taken only when carry set.
// - untaken one cycle, taken adds nop cycles, one basic, three extended.
// - offset is signed words from next address.

module bfib_exec
   import bfib_pkg::*;
(
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    resetn,
   // instruction issue
   input  wire logic                    instrValid,
   output logic                         instrReady,
   input  wire logic [`BFIB_IW_W-1:0]   instrWord1,
   input  wire logic [`BFIB_IW_W-1:0]   instrWord2,
   input  wire logic [`BFIB_PC_W-1:0]   pcNow,
   output logic                         opHit,
   output logic                         opDone,
   // core state and variant
   input  wire logic                    carryFlag,
   input  wire logic                    extendedCore,
   // operand reads, same cycle as issue
   output logic      [3:0]              workSourceSel,
   input  wire logic [`BFIB_DW_W-1:0]   workSourceData,
   output logic      [3:0]              destRegSel,
   output logic      [2:0]              destRegMode,
   output logic      [`BFIB_DW_W-1:0]   destFileAddr,
   input  wire logic [`BFIB_DW_W-1:0]   destCurData,
   // write back
   output logic                         fileWrEn,
   output logic      [`BFIB_DW_W-1:0]   fileWrAddr,
   output logic                         regWrEn,
   output logic      [3:0]              regWrSel,
   output logic      [2:0]              regWrMode,
   output logic      [`BFIB_DW_W-1:0]   wrData,
   output logic                         statusWrEn,
   // program counter
   output logic                         pcLoad,
   output logic      [`BFIB_PC_W-1:0]   pcTargetOut,
   output logic                         nopToIr,
   // panel swap control
   input  wire logic                    dualBootEn,
   input  wire logic                    swapInstrEn,
   input  wire logic                    memoryUnlockKeyOk,
   input  wire logic                    softSwapClear,
   output logic                         activePanelFlag,
   output logic                         softSwapDoneFlag
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   bfib_state_e           state_reg;
   bfib_state_e           state_next;
   bfib_op_e              op_reg;
   bfib_op_e              opDecoded;
   logic [2:0]            cyclesLeft_reg;
   logic [2:0]            opCycles;
   logic                  takeOp;
   logic                  branchTaken;
   logic [15:0]           offsetSel;
   logic [`BFIB_PC_W-1:0] pcTarget;
   logic [`BFIB_DW_W-1:0] insertSrc;
   logic [`BFIB_DW_W-1:0] mergedData;
   logic                  swapPermit;
   logic [3:0]            lowPos;
   logic [3:0]            highPos;
   logic                  fileWrEn_reg;
   logic [`BFIB_DW_W-1:0] fileWrAddr_reg;
   logic                  regWrEn_reg;
   logic [3:0]            regWrSel_reg;
   logic [2:0]            regWrMode_reg;
   logic [`BFIB_DW_W-1:0] wrData_reg;
   logic                  pcLoad_reg;
   logic [`BFIB_PC_W-1:0] pcTarget_reg;
   logic                  activePanel_reg;
   logic                  softSwapDone_reg;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   always_comb begin
      opDecoded = BFIB_OP_NONE;
      if (instrWord1[23:12] == `BFIB_INSF_OPC &&
          instrWord2[23:16] == `BFIB_W2_HI_ZERO) begin
         opDecoded = BFIB_OP_INSF;
      end else if (instrWord1[23:8] == `BFIB_INSL_OPC &&
                   instrWord2[23:16] == `BFIB_W2_HI_ZERO &&
                   instrWord2[7] == 1'b0) begin
         opDecoded = BFIB_OP_INSL;
      end else if (instrWord1 == `BFIB_SWAP_OPC) begin
         opDecoded = BFIB_OP_SWAP;
      end else if (instrWord1[23:16] == `BFIB_BRA_OPC) begin
         opDecoded = BFIB_OP_BRA;
      end else if (instrWord1[23:16] == `BFIB_BRC_OPC) begin
         opDecoded = BFIB_OP_BRC;
      end else if (instrWord1[23:4] == `BFIB_BRW_OPC) begin
         opDecoded = BFIB_OP_BRW;
      end
   end

   assign instrReady = (state_reg == BFIB_ST_IDLE);
   assign opHit      = instrValid && (opDecoded != BFIB_OP_NONE);
   assign takeOp     = instrValid && instrReady && (opDecoded != BFIB_OP_NONE);

   // ------------------------------------------------------------
   // operand fields
   // ------------------------------------------------------------
   assign lowPos        = instrWord1[`BFIB_LOW_LSB +: 4];
   assign highPos       = instrWord1[`BFIB_HIGH_LSB +: 4];
   assign workSourceSel = (opDecoded == BFIB_OP_BRW) ? instrWord1[3:0]
                                                     : instrWord1[`BFIB_WSRC_LSB +: 4];
   assign destRegSel    = instrWord2[3:0];
   assign destRegMode   = instrWord2[`BFIB_MODE_LSB +: 3];
   assign destFileAddr  = {instrWord2[15:1], 1'b0};

   // literal zero-extended, field taken from its lsb
   assign insertSrc = (opDecoded == BFIB_OP_INSL) ?
                      {8'h00, instrWord2[`BFIB_LIT_LSB +: 8]} : workSourceData;

   bfib_field_insert u_insert (
      .lowPos     (lowPos),
      .highPos    (highPos),
      .srcData    (insertSrc),
      .dstData    (destCurData),
      .mergedData (mergedData)
   );

   // ------------------------------------------------------------
   // branch target and condition
   // ------------------------------------------------------------
   assign offsetSel   = (opDecoded == BFIB_OP_BRW) ? workSourceData
                                                   : instrWord1[15:0];
   assign branchTaken = (opDecoded == BFIB_OP_BRA) ||
                        (opDecoded == BFIB_OP_BRW) ||
                        ((opDecoded == BFIB_OP_BRC) && carryFlag);

   bfib_branch_target u_target (
      .pcNow      (pcNow),
      .wordOffset (offsetSel),
      .pcTarget   (pcTarget)
   );

   // ------------------------------------------------------------
   // cycle count per operation
   // ------------------------------------------------------------
   always_comb begin
      case (opDecoded)
         BFIB_OP_INSF,
         BFIB_OP_INSL: opCycles = `BFIB_CYC_INSERT;
         BFIB_OP_SWAP: opCycles = `BFIB_CYC_SWAP;
         BFIB_OP_BRA,
         BFIB_OP_BRW:  opCycles = extendedCore ? `BFIB_CYC_BR_EXT
                                               : `BFIB_CYC_BR_BASIC;
         BFIB_OP_BRC:  opCycles = !carryFlag ? 3'd1 :
                                  (extendedCore ? `BFIB_CYC_BR_EXT
                                                : `BFIB_CYC_BR_BASIC);
         default:      opCycles = 3'd1;
      endcase
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BFIB_ST_IDLE: begin
            if (takeOp && opCycles > 3'd1) begin
               state_next = BFIB_ST_EXEC;
            end
         end
         BFIB_ST_EXEC: begin
            if (cyclesLeft_reg == 3'd1) begin
               state_next = BFIB_ST_IDLE;
            end
         end
         default: state_next = BFIB_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_reg <= BFIB_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cyclesLeft_reg <= 3'd0;
         op_reg         <= BFIB_OP_NONE;
      end else if (takeOp) begin
         cyclesLeft_reg <= opCycles - 3'd1;
         op_reg         <= opDecoded;
      end else if (state_reg == BFIB_ST_EXEC) begin
         cyclesLeft_reg <= cyclesLeft_reg - 3'd1;
      end
   end

   // untaken carry branch finishes in its issue cycle
   assign opDone  = (takeOp && opCycles == 3'd1) ||
                    (state_reg == BFIB_ST_EXEC && cyclesLeft_reg == 3'd1);
   assign nopToIr = (state_reg == BFIB_ST_EXEC) &&
                    (op_reg == BFIB_OP_BRA || op_reg == BFIB_OP_BRW ||
                     op_reg == BFIB_OP_BRC);

   // ------------------------------------------------------------
   // write back, one pulse in the cycle after issue
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         fileWrEn_reg   <= 1'b0;
         regWrEn_reg    <= 1'b0;
         fileWrAddr_reg <= 16'h0000;
         regWrSel_reg   <= 4'h0;
         regWrMode_reg  <= 3'h0;
         wrData_reg     <= 16'h0000;
      end else begin
         fileWrEn_reg <= takeOp && (opDecoded == BFIB_OP_INSF);
         regWrEn_reg  <= takeOp && (opDecoded == BFIB_OP_INSL);
         if (takeOp) begin
            fileWrAddr_reg <= destFileAddr;
            regWrSel_reg   <= destRegSel;
            regWrMode_reg  <= destRegMode;
            wrData_reg     <= mergedData;
         end
      end
   end

   // ------------------------------------------------------------
   // program counter load
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         pcLoad_reg   <= 1'b0;
         pcTarget_reg <= 24'h000000;
      end else begin
         pcLoad_reg <= takeOp && branchTaken;
         if (takeOp && branchTaken) begin
            pcTarget_reg <= pcTarget;
         end
      end
   end

   // ------------------------------------------------------------
   // panel swap flags
   // ------------------------------------------------------------
   assign swapPermit = dualBootEn && swapInstrEn && memoryUnlockKeyOk;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         activePanel_reg <= `BFIB_ACTIVE_RST;
      end else if (takeOp && opDecoded == BFIB_OP_SWAP && swapPermit) begin
         activePanel_reg <= !activePanel_reg;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!resetn) begin
         softSwapDone_reg <= `BFIB_SWAPDONE_RST;
      end else if (takeOp && opDecoded == BFIB_OP_SWAP && swapPermit) begin
         softSwapDone_reg <= 1'b1;
      end else if (softSwapClear) begin
         softSwapDone_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign fileWrEn         = fileWrEn_reg;
   assign fileWrAddr       = fileWrAddr_reg;
   assign regWrEn          = regWrEn_reg;
   assign regWrSel         = regWrSel_reg;
   assign regWrMode        = regWrMode_reg;
   assign wrData           = wrData_reg;
   assign statusWrEn       = 1'b0;
   assign pcLoad           = pcLoad_reg;
   assign pcTargetOut      = pcTarget_reg;
   assign activePanelFlag  = activePanel_reg;
   assign softSwapDoneFlag = softSwapDone_reg;

endmodule

// [dv/bfib_exec_props.sv]
`timescale 1ns/1ps

module bfib_exec_props (
   // clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // issue
   input wire logic        instrValid,
   input wire logic        instrReady,
   input wire logic        opHit,
   input wire logic        opDone,
   input wire logic [23:0] instrWord1,
   input wire logic [23:0] instrWord2,
   input wire logic [23:0] pcNow,
   input wire logic        carryFlag,
   input wire logic        extendedCore,
   input wire logic [15:0] workSourceData,
   // results
   input wire logic        fileWrEn,
   input wire logic [15:0] fileWrAddr,
   input wire logic        regWrEn,
   input wire logic [3:0]  regWrSel,
   input wire logic [2:0]  regWrMode,
   input wire logic        statusWrEn,
   input wire logic        pcLoad,
   input wire logic [23:0] pcTargetOut,
   input wire logic        nopToIr,
   // panel swap
   input wire logic        dualBootEn,
   input wire logic        swapInstrEn,
   input wire logic        memoryUnlockKeyOk,
   input wire logic        activePanelFlag,
   input wire logic        softSwapDoneFlag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   logic issue, isIns, isLit, isSwap, isBra, isBrc, isBrw, taken;
   assign issue  = instrValid && instrReady && opHit;
   assign isIns  = instrWord1[23:12] == 12'h0A2;
   assign isLit  = instrWord1[23:8] == 16'h0A40;
   assign isSwap = instrWord1 == 24'hFE2000;
   assign isBra  = instrWord1[23:16] == 8'h37;
   assign isBrc  = instrWord1[23:16] == 8'h31;
   assign isBrw  = instrWord1[23:4] == 20'h02060;
   assign taken  = isBra || isBrw || (isBrc && carryFlag);

   function automatic logic [23:0] target(input logic [23:0] pc, input logic [23:0] o);
      return pc + 24'h000002 + {{7{o[15]}}, o[15:0], 1'b0};
   endfunction

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_status_quiet; !statusWrEn; endproperty
   property p_file_insert; issue && isIns |=> fileWrEn && !regWrEn && opDone
      && fileWrAddr == (16'($past(instrWord2)) & 16'hFFFE); endproperty
   property p_lit_insert; issue && isLit |=> regWrEn && !fileWrEn && opDone
      && {regWrMode, regWrSel} == 7'($past(instrWord2)); endproperty
   property p_bra_target; issue && isBra |=> pcLoad
      && pcTargetOut == target($past(pcNow), $past(instrWord1)); endproperty
   property p_brw_target; issue && isBrw |=> pcLoad
      && pcTargetOut == target($past(pcNow), 24'($past(workSourceData))); endproperty
   property p_brc_skip; issue && isBrc && !carryFlag |-> opDone ##1 !pcLoad && !nopToIr;
   endproperty
   property p_ext_branch; issue && taken && extendedCore
      |=> (nopToIr && !opDone)[*2] ##1 (nopToIr && opDone); endproperty
   property p_basic_branch; issue && taken && !extendedCore |=> opDone && nopToIr;
   endproperty
   property p_swap_len; issue && isSwap |=> opDone && !pcLoad && !fileWrEn && !regWrEn;
   endproperty
   property p_swap_off; issue && isSwap && !(dualBootEn && swapInstrEn)
      |=> $stable(activePanelFlag); endproperty
   property p_swap_on; issue && isSwap && dualBootEn && swapInstrEn && memoryUnlockKeyOk
      |=> activePanelFlag != $past(activePanelFlag) && softSwapDoneFlag; endproperty

   a_status_quiet: assert property (p_status_quiet)
      else $error("status write strobe raised");
   a_file_insert: assert property (p_file_insert)
      else $error("file insert write wrong");
   a_lit_insert: assert property (p_lit_insert)
      else $error("literal insert write wrong");
   a_bra_target: assert property (p_bra_target)
      else $error("relative branch target wrong");
   a_brw_target: assert property (p_brw_target)
      else $error("computed branch target wrong");
   a_brc_skip: assert property (p_brc_skip)
      else $error("untaken carry branch misbehaved");
   a_ext_branch: assert property (p_ext_branch)
      else $error("extended branch timing wrong");
   a_basic_branch: assert property (p_basic_branch)
      else $error("basic branch timing wrong");
   a_swap_len: assert property (p_swap_len)
      else $error("panel swap timing wrong");
   a_swap_off: assert property (p_swap_off)
      else $error("disabled panel swap changed flag");
   a_swap_on: assert property (p_swap_on)
      else $error("enabled panel swap flags wrong");

   c_swap: cover property (issue && isSwap && dualBootEn && swapInstrEn);
   c_ext_carry: cover property (issue && isBrc && carryFlag && extendedCore);
   c_insert: cover property (issue && isIns);
endmodule

bind bfib_exec bfib_exec_props u_props (.clock, .resetn, .instrValid, .instrReady, .opHit,
   .opDone, .instrWord1, .instrWord2, .pcNow, .carryFlag, .extendedCore, .workSourceData,
   .fileWrEn, .fileWrAddr, .regWrEn, .regWrSel, .regWrMode, .statusWrEn, .pcLoad,
   .pcTargetOut, .nopToIr, .dualBootEn, .swapInstrEn, .memoryUnlockKeyOk, .activePanelFlag,
   .softSwapDoneFlag);

// [dv/tb_bitfield_insert_branch_exec.sv]
`timescale 1ns/1ps

module tb_bitfield_insert_branch_exec;
   logic        clock = 0, resetn = 0, instrValid = 0, carryFlag = 0, extendedCore = 0;
   logic        dualBootEn = 0, swapInstrEn = 0, memoryUnlockKeyOk = 0, softSwapClear = 0;
   logic [23:0] instrWord1 = '0, instrWord2 = '0, pcNow = '0, pcTargetOut, w1, w2;
   logic [15:0] workSourceData = '0, destCurData = '0, destFileAddr, fileWrAddr, wrData;
   logic [3:0]  workSourceSel, destRegSel, regWrSel;
   logic [2:0]  destRegMode, regWrMode;
   logic        instrReady, opHit, opDone, fileWrEn, regWrEn, statusWrEn, pcLoad, nopToIr;
   logic        activePanelFlag, softSwapDoneFlag, expAct = 0, expDone = 0;
   logic [31:0] o;
   int          n_fail = 0, n_compared = 0, cycles = 0;

   bfib_exec dut_u (.clock, .resetn, .instrValid, .instrReady, .instrWord1, .instrWord2,
      .pcNow, .opHit, .opDone, .carryFlag, .extendedCore, .workSourceSel, .workSourceData,
      .destRegSel, .destRegMode, .destFileAddr, .destCurData, .fileWrEn, .fileWrAddr,
      .regWrEn, .regWrSel, .regWrMode, .wrData, .statusWrEn, .pcLoad, .pcTargetOut,
      .nopToIr, .dualBootEn, .swapInstrEn, .memoryUnlockKeyOk, .softSwapClear,
      .activePanelFlag, .softSwapDoneFlag);

   always #50 clock = ~clock;

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         test_done();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic [15:0] ins(input logic [3:0] lo, hi, input logic [15:0] s, d);
      logic [15:0] m;
      m = '0;
      for (int i = 0; i < 16; i++) if (i >= lo && i <= hi) m[i] = 1'b1;
      return (d & ~m) | ((s << lo) & m);
   endfunction

   function automatic logic [23:0] tgt(input logic [23:0] pc, input logic [15:0] o);
      return pc + 24'h000002 + {{7{o[15]}}, o, 1'b0};
   endfunction

   // one instruction, valid dropped once the block is busy, run until it is ready again
   task automatic run(input logic [23:0] a, b, input logic [15:0] src, cur);
      logic        fi, li, sw, bc, bw, tk, hit;
      logic [23:0] ex, d, w, p, q;
      fi = a[23:12] == 12'h0A2;
      li = a[23:8] == 16'h0A40;
      sw = a == 24'hFE2000;
      bc = a[23:16] == 8'h31;
      bw = a[23:4] == 20'h02060;
      tk = a[23:16] == 8'h37 || bw || (bc && carryFlag);
      hit = fi || li || sw || bc || tk;
      ex = !hit ? 0 : (bc && !carryFlag) ? 1 : (tk && extendedCore) ? 4 : 2;
      d = '0;
      w = '0;
      p = '0;
      q = '0;
      instrWord1 = a;
      instrWord2 = b;
      workSourceData = src;
      destCurData = cur;
      instrValid = 1;
      for (int n = 1; n <= 6; n++) begin
         #1;
         if (n == 1) begin
            check(opHit, hit, "decode hit");
            if (fi) check(destFileAddr, {b[15:1], 1'b0}, "file address");
            if (fi) check(workSourceSel, a[11:8], "source select");
            if (bw) check(workSourceSel, a[3:0], "offset select");
            if (li) check({destRegMode, destRegSel}, b[6:0], "dest select");
         end
         if (opDone === 1'b1 && d == 0) d = n;
         if (fileWrEn === 1'b1) w = w + 24'd1;
         if (regWrEn === 1'b1) w = w + 24'd2;
         if (pcLoad === 1'b1) p++;
         if (nopToIr === 1'b1 && n > 1) q++;
         if (n > 1 && instrReady === 1'b1) break;
         @(negedge clock);
         if (instrReady !== 1'b1) instrValid = 0;
      end
      check(d, ex, "cycle count");
      check(p, tk, "pc loads");
      check(w, fi ? 1 : (li ? 2 : 0), "write pulses");
      check(q, tk ? ex - 1 : 0, "nop cycles");
      if (tk) check(pcTargetOut, tgt(pcNow, bw ? src : a[15:0]), "target");
      if (fi || li) check(wrData, ins(a[3:0], a[7:4], fi ? src : {8'h00, b[15:8]}, cur),
         "merged word");
      if (fi) check(fileWrAddr, {b[15:1], 1'b0}, "write address");
      if (li) check({regWrMode, regWrSel}, b[6:0], "write select");
      if (sw && dualBootEn && swapInstrEn && memoryUnlockKeyOk) begin
         expAct = ~expAct;
         expDone = 1'b1;
      end
      check({activePanelFlag, softSwapDoneFlag}, {expAct, expDone}, "panel flags");
      check(statusWrEn, 0, "status strobe");
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      o = $urandom(32'h39CE);
      repeat (3) @(negedge clock);
      #1;
      check({instrReady, pcLoad, activePanelFlag, softSwapDoneFlag}, 4'h8, "reset state");
      resetn = 1;
      @(negedge clock);
      run(24'h0A23F0, 24'h00ABCE, 16'hFFFF, 16'h0000);
      run(24'h0A40FF, 24'h00FF25, 16'h0000, 16'h1234);
      run(24'h0A2125, 24'h000010, 16'h00FF, 16'hAAAA);
      for (int e = 0; e < 2; e++) begin
         extendedCore = e[0];
         pcNow = 24'h002000;
         run(24'h378000, 24'h000000, 16'h0000, 16'h0000);
         run(24'h377FFF, 24'h000000, 16'h0000, 16'h0000);
         run(24'h020607, 24'h000000, 16'h8000, 16'h0000);
         carryFlag = 0;
         run(24'h310004, 24'h000000, 16'h0000, 16'h0000);
         run(24'h310004, 24'h000000, 16'h0000, 16'h0000);
         carryFlag = 1;
         run(24'h310004, 24'h000000, 16'h0000, 16'h0000);
         {dualBootEn, swapInstrEn, memoryUnlockKeyOk} = {2'b10, e[0]};
         run(24'hFE2000, 24'h000000, 16'h0000, 16'h0000);
         swapInstrEn = 1;
         run(24'hFE2000, 24'h000000, 16'h0000, 16'h0000);
         run(24'h123456, 24'h000000, 16'h0000, 16'h0000);
      end
      instrValid = 0;
      softSwapClear = 1;
      @(negedge clock);
      softSwapClear = 0;
      expDone = 0;
      #1;
      check(softSwapDoneFlag, expDone, "swap done clear");
      resetn = 0;
      @(negedge clock);
      resetn = 1;
      expAct = 0;
      #1;
      check(activePanelFlag, expAct, "panel after reset");
      @(negedge clock);
      for (int i = 0; i < 300; i++) begin
         o = $urandom;
         {carryFlag, extendedCore} = o[31:30];
         dualBootEn = o[29] | o[28];
         swapInstrEn = o[27] | o[26];
         memoryUnlockKeyOk = o[25] | o[24];
         pcNow = 24'($urandom) & 24'hFFFFFE;
         case ($urandom % 7)
            0: w1 = {12'h0A2, o[11:0]};
            1: w1 = {16'h0A40, o[7:0]};
            2: w1 = 24'hFE2000;
            3: w1 = {8'h37, o[15:0]};
            4: w1 = {8'h31, o[15:0]};
            5: w1 = {20'h02060, o[3:0]};
            default: w1 = {8'hA5, o[15:0]};
         endcase
         w2 = 24'($urandom) & (w1[23:12] == 12'h0A2 ? 24'h00FFFE : 24'h00FF7F);
         run(w1, w2, 16'($urandom), 16'($urandom));
      end
      instrValid = 0;
      repeat (2) @(negedge clock);
      test_done();
   end
endmodule
